/* File: rtl/spsel_supervisor.sv */
`timescale 1ns/1ps
module spsel_supervisor
  import spsel_pkg::*;
#(
  parameter int unsigned CYC_PER_MIN_P = CYC_PER_MIN,
  parameter int unsigned CYC_PER_SEC_P = CYC_PER_SEC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Pins from the field
  input  wire logic        logic_in1_closed,
  input  wire logic        logic_in2_closed,
  input  wire logic        sensor_open,
  input  wire logic        break_jumper_over,
  // Setpoint configuration
  input  wire logic [15:0] main_setpoint,
  input  wire logic [15:0] aux_setpoint_b,
  input  wire logic [15:0] aux_setpoint_c,
  input  wire logic [15:0] aux_setpoint_d,
  input  wire logic [15:0] setpoint_floor,
  input  wire logic [15:0] setpoint_ceiling,
  input  wire logic [15:0] rise_ramp_rate,
  input  wire logic [15:0] fall_ramp_rate,
  // Parameter lock key
  input  wire logic        lock_key_on,
  input  wire logic [15:0] unlock_password,
  input  wire logic [15:0] key_entry,
  input  wire logic        key_entry_stb,
  // Measurement from the converter
  input  wire logic [2:0]  input_range_select,
  input  wire logic [15:0] pv_value,
  input  wire logic [15:0] span_low,
  input  wire logic [15:0] span_high,
  input  wire logic [15:0] rtd_ohms,
  // Output configuration and control demand
  input  wire logic        heat_cool_mode,
  input  wire logic        heating_type_action,
  input  wire logic [7:0]  safety_output_condition,
  input  wire logic [7:0]  safety_output_value,
  input  wire logic [7:0]  output_ceiling_limit,
  input  wire logic [7:0]  limiter_duration,
  input  wire logic [7:0]  output_slew_limit,
  input  wire logic [7:0]  pid_demand,
  input  wire logic        pid_main_on,
  input  wire logic        pid_cool_on,
  // Self-test result from the integrity checks
  input  wire logic [9:0]  selftest_code,
  // Status and outputs
  output logic [15:0]      active_setpoint_q,
  output logic [15:0]      sp_tgt_q,
  output logic             params_locked_q,
  output logic             fault_over_q,
  output logic             fault_under_q,
  output logic             out_main_q,
  output logic             out_cool_q,
  output logic [7:0]       ctrl_out_q,
  output logic             err_flag_q,
  output logic [9:0]       err_code_q
);

  logic l1_s, l2_s, open_s, jump_s;

  spsel_sync2 #(.W(4)) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d_in    ({logic_in1_closed, logic_in2_closed, sensor_open,
                break_jumper_over}),
    .q_out   ({l1_s, l2_s, open_s, jump_s})
  );

  spsel_state_e st_q, st_d;
  logic [15:0]  st_cnt_q, st_cnt_d;
  logic [15:0]  sp_sel, sp_tgt_d, sp_d, ramp_rate;
  logic [31:0]  ramp_acc_q, ramp_acc_d, ramp_sum;
  logic         lock_d, key_prev_q;
  logic         over_d, under_d, is_rtd, is_elev, is_tcmv;
  logic         main_d, cool_d, main_heat, bypass;
  logic [7:0]   ctrl_tgt, ctrl_d, cap;
  logic [31:0]  slew_acc_q, slew_acc_d, slew_sum;
  logic [31:0]  min_acc_q, min_acc_d;
  logic [7:0]   min_cnt_q, min_cnt_d;
  logic         limit_on, err_flag_d;
  logic [9:0]   err_code_d;

  // Self-test sequence; outputs stay off until it passes
  always_comb begin
    st_d       = st_q;
    st_cnt_d   = st_cnt_q;
    err_flag_d = err_flag_q;
    err_code_d = err_code_q;
    case (st_q)
      ST_SELFTEST: begin
        st_cnt_d = st_cnt_q + SP_STEP;
        if (st_cnt_q == 16'(SELFTEST_CYC - 1)) begin
          if (selftest_code != ERR_NONE) begin
            st_d       = ST_ERROR;
            err_flag_d = 1'b1;
            err_code_d = selftest_code;
          end else begin
            st_d = ST_RUN;
          end
        end
      end
      ST_RUN:   st_d = ST_RUN;
      ST_ERROR: st_d = ST_ERROR;
      default:  st_d = ST_SELFTEST;
    endcase
  end

  // Setpoint selection, clamp and ramp
  always_comb begin
    case ({l1_s, l2_s})
      2'b01:   sp_sel = aux_setpoint_b;
      2'b10:   sp_sel = aux_setpoint_c;
      2'b11:   sp_sel = aux_setpoint_d;
      default: sp_sel = main_setpoint;
    endcase
    if (sp_sel < setpoint_floor) begin
      sp_tgt_d = setpoint_floor;
    end else if (sp_sel > setpoint_ceiling) begin
      sp_tgt_d = setpoint_ceiling;
    end else begin
      sp_tgt_d = sp_sel;
    end
    ramp_rate  = (sp_tgt_q > active_setpoint_q) ? rise_ramp_rate
                                                 : fall_ramp_rate;
    ramp_sum   = ramp_acc_q + {16'h0000, ramp_rate};
    sp_d       = active_setpoint_q;
    ramp_acc_d = ACC_RST;
    if (st_q != ST_RUN || ramp_rate == RAMP_INFINITE) begin
      sp_d = sp_tgt_q;
    end else if (sp_tgt_q != active_setpoint_q) begin
      // Fractional credit so slow rates still move at the exact average
      if (ramp_sum >= CYC_PER_MIN_P) begin
        ramp_acc_d = ramp_sum - CYC_PER_MIN_P;
        sp_d = (sp_tgt_q > active_setpoint_q) ? active_setpoint_q + SP_STEP
                                              : active_setpoint_q - SP_STEP;
      end else begin
        ramp_acc_d = ramp_sum;
      end
    end
  end

  // Parameter lock; turning the key on locks straight away
  always_comb begin
    lock_d = params_locked_q;
    if (!lock_key_on) begin
      lock_d = 1'b0;
    end else if (!key_prev_q) begin
      lock_d = 1'b1;
    end else if (key_entry_stb) begin
      if (params_locked_q && key_entry == unlock_password) begin
        lock_d = 1'b0;
      end else if (!params_locked_q && key_entry != unlock_password) begin
        lock_d = 1'b1;
      end
    end
  end

  // Range faults, re-evaluated every cycle so they clear on return
  always_comb begin
    is_rtd  = (input_range_select == RNG_RTD);
    is_tcmv = (input_range_select == RNG_TC) ||
              (input_range_select == RNG_MV);
    is_elev = (input_range_select == RNG_MA_4_20) ||
              (input_range_select == RNG_V_1_5) ||
              (input_range_select == RNG_V_2_10);
    over_d  = (pv_value > span_high) ||
              (open_s && (is_rtd || (is_tcmv && jump_s))) ||
              (is_rtd && rtd_ohms < RTD_SHORT_OHMS);
    under_d = !over_d && ((pv_value < span_low) ||
              (open_s && (is_elev || (is_tcmv && !jump_s))));
  end

  // Output limiting, safety states and slew
  always_comb begin
    limit_on  = (limiter_duration == LIMIT_DUR_INF) ||
                (min_cnt_q < limiter_duration);
    cap       = limit_on ? output_ceiling_limit : PCT_FULL;
    main_heat = heat_cool_mode || heating_type_action;
    bypass    = 1'b1;
    main_d    = 1'b0;
    cool_d    = 1'b0;
    ctrl_tgt  = OUT_RST;
    if (st_q != ST_RUN) begin
      ctrl_tgt = OUT_RST;
    end else if (fault_over_q || fault_under_q) begin
      if (safety_output_condition == 8'h00) begin
        if (fault_over_q) begin
          main_d = !main_heat;
          cool_d = heat_cool_mode;
        end else begin
          main_d = main_heat;
          cool_d = 1'b0;
        end
        ctrl_tgt = main_d ? PCT_FULL : OUT_RST;
      end else begin
        main_d   = (safety_output_value != OUT_RST);
        ctrl_tgt = (safety_output_value > PCT_FULL) ? PCT_FULL
                                                    : safety_output_value;
      end
    end else begin
      bypass   = 1'b0;
      main_d   = pid_main_on;
      cool_d   = pid_cool_on && heat_cool_mode;
      ctrl_tgt = (pid_demand > cap) ? cap : pid_demand;
    end
    // Safety states skip the slew so the process is made safe at once
    slew_sum   = slew_acc_q + {24'h00_0000, output_slew_limit};
    slew_acc_d = ACC_RST;
    ctrl_d     = ctrl_tgt;
    if (!bypass && ctrl_tgt > ctrl_out_q) begin
      ctrl_d = ctrl_out_q;
      if (slew_sum >= CYC_PER_SEC_P) begin
        ctrl_d     = ctrl_out_q + PCT_STEP;
        slew_acc_d = slew_sum - CYC_PER_SEC_P;
      end else begin
        slew_acc_d = slew_sum;
      end
    end
    min_acc_d = min_acc_q;
    min_cnt_d = min_cnt_q;
    if (st_q == ST_RUN && min_cnt_q != LIMIT_DUR_INF) begin
      if (min_acc_q == CYC_PER_MIN_P - 1) begin
        min_acc_d = ACC_RST;
        min_cnt_d = min_cnt_q + PCT_STEP;
      end else begin
        min_acc_d = min_acc_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q              <= ST_SELFTEST;
      st_cnt_q          <= SP_RST;
      err_flag_q        <= 1'b0;
      err_code_q        <= ERR_NONE;
      sp_tgt_q          <= SP_RST;
      active_setpoint_q <= SP_RST;
      ramp_acc_q        <= ACC_RST;
      params_locked_q   <= LOCK_RST;
      key_prev_q        <= 1'b0;
      fault_over_q      <= 1'b0;
      fault_under_q     <= 1'b0;
      out_main_q        <= 1'b0;
      out_cool_q        <= 1'b0;
      ctrl_out_q        <= OUT_RST;
      slew_acc_q        <= ACC_RST;
      min_acc_q         <= ACC_RST;
      min_cnt_q         <= MIN_RST;
    end else begin
      st_q              <= st_d;
      st_cnt_q          <= st_cnt_d;
      err_flag_q        <= err_flag_d;
      err_code_q        <= err_code_d;
      sp_tgt_q          <= sp_tgt_d;
      active_setpoint_q <= sp_d;
      ramp_acc_q        <= ramp_acc_d;
      params_locked_q   <= lock_d;
      key_prev_q        <= lock_key_on;
      fault_over_q      <= over_d;
      fault_under_q     <= under_d;
      out_main_q        <= main_d;
      out_cool_q        <= cool_d;
      ctrl_out_q        <= ctrl_d;
      slew_acc_q        <= slew_acc_d;
      min_acc_q         <= min_acc_d;
      min_cnt_q         <= min_cnt_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_sel_main;
    (!l1_s && !l2_s && main_setpoint >= setpoint_floor &&
     main_setpoint <= setpoint_ceiling) |=> sp_tgt_q == $past(main_setpoint);
  endproperty
  a_sel_main: assert property (p_sel_main)
    else $error("main sp not chosen");
  property p_sel_aux_d;
    (l1_s && l2_s && aux_setpoint_d >= setpoint_floor &&
     aux_setpoint_d <= setpoint_ceiling) |=> sp_tgt_q == $past(aux_setpoint_d);
  endproperty
  a_sel_aux_d: assert property (p_sel_aux_d)
    else $error("aux D not chosen");
  property p_clamp;
    (setpoint_floor <= setpoint_ceiling) |=>
      (sp_tgt_q >= $past(setpoint_floor) &&
       sp_tgt_q <= $past(setpoint_ceiling));
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("setpoint out of limits");
  property p_unlock;
    (lock_key_on && key_prev_q && params_locked_q && key_entry_stb &&
     key_entry == unlock_password) |=> !params_locked_q;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("password did not unlock");
  property p_over;
    (pv_value > span_high) |=> fault_over_q && !fault_under_q;
  endproperty
  a_over: assert property (p_over)
    else $error("over-range missed");
  property p_rtd_short;
    (input_range_select == RNG_RTD && rtd_ohms < RTD_SHORT_OHMS)
      |=> fault_over_q;
  endproperty
  a_rtd_short: assert property (p_rtd_short)
    else $error("short missed");
  property p_safe_over;
    (st_q == ST_RUN && fault_over_q && heat_cool_mode &&
     safety_output_condition == 8'h00) |=> !out_main_q && out_cool_q;
  endproperty
  a_safe_over: assert property (p_safe_over)
    else $error("over safe state");
  property p_safe_under;
    (st_q == ST_RUN && fault_under_q && heat_cool_mode &&
     safety_output_condition == 8'h00) |=> out_main_q && !out_cool_q;
  endproperty
  a_safe_under: assert property (p_safe_under)
    else $error("under safe state");
  property p_ramp_step;
    (st_q == ST_RUN && rise_ramp_rate != RAMP_INFINITE &&
     sp_tgt_q > active_setpoint_q) |=>
      active_setpoint_q <= $past(active_setpoint_q) + SP_STEP;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp too fast");
  property p_slew;
    (st_q == ST_RUN && !fault_over_q && !fault_under_q) |=>
      ctrl_out_q <= $past(ctrl_out_q) + PCT_STEP;
  endproperty
  a_slew: assert property (p_slew)
    else $error("output rose too fast");
  property p_cap;
    (limiter_duration == LIMIT_DUR_INF && !fault_over_q && !fault_under_q &&
     ctrl_out_q <= output_ceiling_limit) |=>
      ctrl_out_q <= $past(output_ceiling_limit);
  endproperty
  a_cap: assert property (p_cap)
    else $error("output above ceiling");

endmodule : spsel_supervisor

/* File: rtl/spsel_pkg.sv */
package spsel_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned CYC_PER_SEC   = CLK_HZ;
  localparam int unsigned CYC_PER_MIN   = CLK_HZ * SEC_PER_MIN;

  // Power-up self-test window, a least time so it rounds up
  localparam int unsigned SELFTEST_NS  = 50_000;
  localparam int unsigned SELFTEST_CYC =
    (SELFTEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Input range selection codes
  localparam logic [2:0] RNG_TC      = 3'h0;
  localparam logic [2:0] RNG_MV      = 3'h1;
  localparam logic [2:0] RNG_RTD     = 3'h2;
  localparam logic [2:0] RNG_MA_4_20 = 3'h3;
  localparam logic [2:0] RNG_V_1_5   = 3'h4;
  localparam logic [2:0] RNG_V_2_10  = 3'h5;
  localparam logic [2:0] RNG_MA_0_20 = 3'h6;
  localparam logic [2:0] RNG_V_0_10  = 3'h7;

  // Thresholds and special settings
  localparam logic [15:0] RTD_SHORT_OHMS = 16'h000F;
  localparam logic [15:0] RAMP_INFINITE  = 16'h0000;
  localparam logic [7:0]  LIMIT_DUR_INF  = 8'hFF;
  localparam logic [7:0]  PCT_FULL       = 8'h64;
  localparam logic [7:0]  PCT_STEP       = 8'h01;
  localparam logic [15:0] SP_STEP        = 16'h0001;
  localparam logic [9:0]  ERR_NONE       = 10'h000;

  // Reset values
  localparam logic [15:0] SP_RST   = 16'h0000;
  localparam logic [7:0]  OUT_RST  = 8'h00;
  localparam logic        LOCK_RST = 1'b1;
  localparam logic [31:0] ACC_RST  = 32'h0000_0000;
  localparam logic [7:0]  MIN_RST  = 8'h00;

  typedef enum logic [1:0] {
    ST_SELFTEST,
    ST_RUN,
    ST_ERROR
  } spsel_state_e;

endpackage : spsel_pkg

/* File: rtl/spsel_sync2.sv */
`timescale 1ns/1ps
module spsel_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule : spsel_sync2

/* File: testbench/spsel_field_model.sv */
`timescale 1ns/1ps
module spsel_field_model (
  // Clock
  input  wire logic        clk_sys,
  // Commands from the bench
  input  wire logic [15:0] meas_cmd,
  input  wire logic        break_cmd,
  input  wire logic [15:0] ohms_cmd,
  // Controller outputs driving the contactors
  input  wire logic        out_main_q,
  input  wire logic        out_cool_q,
  // Sensor side towards the controller
  output logic [15:0]      pv_value,
  output logic             sensor_open,
  output logic [15:0]      rtd_ohms,
  // Contactor state
  output logic             heater_on,
  output logic             cooler_on
);
  initial begin
    pv_value    = 16'h01F4;
    sensor_open = 1'b0;
    rtd_ohms    = 16'h0064;
    heater_on   = 1'b0;
    cooler_on   = 1'b0;
  end
  // Front end moves off the sampling edge, like a slow converter
  always @(negedge clk_sys) begin
    pv_value    <= meas_cmd;
    sensor_open <= break_cmd;
    // An open element reads as a huge resistance, never as a short
    rtd_ohms    <= break_cmd ? 16'hFFFF : ohms_cmd;
  end
  // Contactors pull in one cycle after the coil is driven
  always @(posedge clk_sys) begin
    heater_on <= out_main_q;
    cooler_on <= out_cool_q;
  end
endmodule : spsel_field_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb_top;
  import spsel_pkg::*;
  logic clk_sys, sys_rst, logic_in1_closed, logic_in2_closed;
  logic break_jumper_over, lock_key_on, key_entry_stb, heat_cool_mode;
  logic heating_type_action, pid_main_on, pid_cool_on, sensor_open;
  logic break_cmd, heater_on, cooler_on, params_locked_q, fault_over_q;
  logic fault_under_q, out_main_q, out_cool_q, err_flag_q;
  logic [15:0] main_setpoint, aux_setpoint_b, aux_setpoint_c;
  logic [15:0] aux_setpoint_d, setpoint_floor, setpoint_ceiling;
  logic [15:0] rise_ramp_rate, fall_ramp_rate, unlock_password, key_entry;
  logic [15:0] pv_value, span_low, span_high, rtd_ohms, meas_cmd, ohms_cmd;
  logic [15:0] active_setpoint_q, sp_tgt_q;
  logic [7:0]  safety_output_condition, safety_output_value, pid_demand;
  logic [7:0]  output_ceiling_limit, limiter_duration, output_slew_limit;
  logic [7:0]  ctrl_out_q;
  logic [2:0]  input_range_select;
  logic [9:0]  selftest_code, err_code_q;
  logic [15:0] sel_exp [4];
  logic        em, ec;
  int          bad_count, num_checks;

  // Minute and second shortened so ramps and slews finish quickly
  spsel_supervisor #(.CYC_PER_MIN_P(60), .CYC_PER_SEC_P(10)) DUT (
    .clk_sys, .sys_rst, .logic_in1_closed, .logic_in2_closed,
    .sensor_open, .break_jumper_over, .main_setpoint, .aux_setpoint_b,
    .aux_setpoint_c, .aux_setpoint_d, .setpoint_floor, .setpoint_ceiling,
    .rise_ramp_rate, .fall_ramp_rate, .lock_key_on, .unlock_password,
    .key_entry, .key_entry_stb, .input_range_select, .pv_value, .span_low,
    .span_high, .rtd_ohms, .heat_cool_mode, .heating_type_action,
    .safety_output_condition, .safety_output_value, .output_ceiling_limit,
    .limiter_duration, .output_slew_limit, .pid_demand, .pid_main_on,
    .pid_cool_on, .selftest_code, .active_setpoint_q, .sp_tgt_q,
    .params_locked_q, .fault_over_q, .fault_under_q, .out_main_q,
    .out_cool_q, .ctrl_out_q, .err_flag_q, .err_code_q);

  spsel_field_model FIELD (
    .clk_sys, .meas_cmd, .break_cmd, .ohms_cmd, .out_main_q, .out_cool_q,
    .pv_value, .sensor_open, .rtd_ohms, .heater_on, .cooler_on);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    tick(1);
    sys_rst = 1'b0;
  endtask : do_reset

  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic fault_chk(input logic o, input logic u);
    tick(6);
    `CHK("fault_over", o, fault_over_q)
    `CHK("fault_under", u, fault_under_q)
  endtask : fault_chk

  initial begin
    // Cut a hang short well past the planned run length
    #(20_000 * 100);
    bad_count++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1; {logic_in1_closed, logic_in2_closed} = 2'b00;
    break_jumper_over = 1'b0; lock_key_on = 1'b0; key_entry_stb = 1'b0;
    heat_cool_mode = 1'b0; heating_type_action = 1'b1; pid_main_on = 1'b1;
    pid_cool_on = 1'b0; break_cmd = 1'b0; meas_cmd = 16'h01F4;
    ohms_cmd = 16'h0064; span_low = 16'h0064; span_high = 16'h0384;
    sel_exp = '{16'h0064, 16'h00C8, 16'h012C, 16'h0190};
    main_setpoint = sel_exp[0]; aux_setpoint_b = sel_exp[1];
    aux_setpoint_c = sel_exp[2]; aux_setpoint_d = sel_exp[3];
    setpoint_floor = 16'h0000; setpoint_ceiling = 16'hFFFF;
    rise_ramp_rate = RAMP_INFINITE; fall_ramp_rate = RAMP_INFINITE;
    unlock_password = 16'h1234; key_entry = 16'h0000;
    input_range_select = RNG_RTD; safety_output_condition = 8'h00;
    safety_output_value = 8'h00; output_ceiling_limit = PCT_FULL;
    limiter_duration = LIMIT_DUR_INF; output_slew_limit = 8'h0A;
    pid_demand = 8'h00; selftest_code = ERR_NONE;
    bad_count = 0; num_checks = 0;
    do_reset();
    tick(100);
    `CHK("out_in_selftest", 1'b0, out_main_q)
    tick(420);
    `CHK("err_flag_pass", 1'b0, err_flag_q)
    for (int i = 0; i < 4; i++) begin
      {logic_in1_closed, logic_in2_closed} = i[1:0];
      tick(6);
      `CHK("sp_select", sel_exp[i], sp_tgt_q)
      `CHK("sp_step", sel_exp[i], active_setpoint_q)
    end
    {logic_in1_closed, logic_in2_closed} = 2'b00;
    tick(6);
    // Rise 6 digits per minute is one digit per ten cycles here
    rise_ramp_rate = 16'h0006; fall_ramp_rate = 16'h000C;
    main_setpoint = 16'h0069;
    tick(30);
    `CHK("ramp_rise_mid", 1'b1, active_setpoint_q > 16'h0064 &&
         active_setpoint_q < 16'h0069)
    tick(60);
    `CHK("ramp_rise_end", 16'h0069, active_setpoint_q)
    main_setpoint = 16'h005F;
    tick(25);
    `CHK("ramp_fall_mid", 1'b1, active_setpoint_q < 16'h0069 &&
         active_setpoint_q > 16'h005F)
    tick(40);
    `CHK("ramp_fall_end", 16'h005F, active_setpoint_q)
    rise_ramp_rate = RAMP_INFINITE; fall_ramp_rate = RAMP_INFINITE;
    setpoint_floor = 16'h0032; setpoint_ceiling = 16'h03E8;
    main_setpoint = 16'h07D0;
    tick(6);
    `CHK("sp_ceiling", 16'h03E8, sp_tgt_q)
    `CHK("sp_ceiling_act", 16'h03E8, active_setpoint_q)
    main_setpoint = 16'h000A;
    tick(6);
    `CHK("sp_floor", 16'h0032, sp_tgt_q)
    lock_key_on = 1'b1;
    tick(2);
    `CHK("lock_on", 1'b1, params_locked_q)
    key_entry = unlock_password; key_entry_stb = 1'b1;
    tick(1);
    key_entry_stb = 1'b0;
    tick(1);
    `CHK("unlock", 1'b0, params_locked_q)
    key_entry = 16'h1235; key_entry_stb = 1'b1;
    tick(1);
    key_entry_stb = 1'b0;
    tick(1);
    `CHK("relock", 1'b1, params_locked_q)
    // Slew 1 percent per second: one step per ten cycles
    output_slew_limit = 8'h01; pid_demand = 8'h1E;
    tick(50);
    `CHK("slew_slow", 1'b1, ctrl_out_q inside {[8'h03:8'h07]})
    output_slew_limit = 8'h0A; pid_demand = PCT_FULL;
    output_ceiling_limit = 8'h32;
    tick(100);
    `CHK("cap_forever", 8'h32, ctrl_out_q)
    // Limiter time not yet run out, so the cap must still hold
    limiter_duration = 8'h64;
    tick(4);
    `CHK("cap_timed", 8'h32, ctrl_out_q)
    limiter_duration = 8'h00;
    tick(80);
    `CHK("cap_expired", PCT_FULL, ctrl_out_q)
    for (int i = 0; i < 8; i++) begin
      {heat_cool_mode, heating_type_action} = i[1:0];
      meas_cmd = i[2] ? 16'h0032 : 16'h03B6;
      em = i[2] ? (i[1] | i[0]) : !(i[1] | i[0]);
      ec = !i[2] && i[1];
      fault_chk(!i[2], i[2]);
      `CHK("safe_main", em, out_main_q)
      `CHK("safe_cool", ec, out_cool_q)
      tick(1);
      `CHK("heater", em, heater_on)
      meas_cmd = 16'h01F4;
      fault_chk(1'b0, 1'b0);
      `CHK("resume_main", 1'b1, out_main_q)
    end
    safety_output_condition = 8'h01;
    for (int i = 0; i < 3; i++) begin
      safety_output_value = (i == 0) ? 8'h28 : (i == 1) ? 8'h00 : 8'h96;
      meas_cmd = 16'h03B6;
      fault_chk(1'b1, 1'b0);
      `CHK("cond_main", i != 1, out_main_q)
      `CHK("cond_cool", 1'b0, out_cool_q)
      `CHK("cond_ctrl", (i == 2) ? PCT_FULL : safety_output_value,
           ctrl_out_q)
      meas_cmd = 16'h01F4;
      fault_chk(1'b0, 1'b0);
    end
    safety_output_condition = 8'h00;
    for (int i = 0; i < 8; i++) begin
      input_range_select = i[2:0];
      break_jumper_over = (i == 0);
      break_cmd = 1'b1;
      em = (i == 0 || i == 2);
      ec = (i == 1 || (i > 2 && i < 6));
      fault_chk(em, ec);
      break_cmd = 1'b0;
      fault_chk(1'b0, 1'b0);
    end
    input_range_select = RNG_RTD;
    ohms_cmd = 16'h000E;
    fault_chk(1'b1, 1'b0);
    ohms_cmd = RTD_SHORT_OHMS;
    fault_chk(1'b0, 1'b0);
    selftest_code = 10'h133;
    do_reset();
    tick(490);
    `CHK("err_early", 1'b0, err_flag_q)
    tick(20);
    `CHK("err_flag", 1'b1, err_flag_q)
    `CHK("err_code", 10'h133, err_code_q)
    `CHK("err_out_off", 1'b0, out_main_q)
    complete_run();
  end
endmodule : tb_top
